/* rtl/psau_top.sv */
// Program space access unit: table reads and writes, the read-only data
// window into program memory, and self-programming control over APB.
// Assumes the core, the APB master and the program memory share ref_clk;
// program memory answers pm_rd within the cycle in which it stands.
//
// Behaviour
// - Word-mode low table read returns program bits 15..0 as data.
// - Byte-mode low table read returns upper byte if select set, else lower.
// - Word-mode high table read returns bits 23..16; data bits 15..8 zero.
// - Byte-mode high table read of the phantom byte returns zero.
// - Page register top bit picks user or configuration memory.
// - Table address is page register bits 7..0 above the effective address.
// - Window and fetch accesses force program address bit 0 to zero.
// - Data read maps to program memory when address bit 15 and enable set.
// - Window address is window page above effective address bits 14..0.
// - Window read costs one extra cycle for two program fetches.
// - Window read returns only the low 16 bits of the program word.
// - Window mapping is suspended while a table operation executes.
// - Outside repeat, window adds one cycle to moves, two to others.
// - In repeat, edge iterations add two cycles, other iterations none.
// - Rows are 64 instructions, pages eight rows, program row or word.
// - Pages and rows align from address zero on their own size.
// - Holding buffers hold 64 instructions filled from one aligned group.
// - Buffer-loading table writes only touch buffers and take two cycles.
// - Core stalls while a program or erase operation runs.
// - Operations last a fixed count of fast oscillator cycles.
// - Setting write-start launches the operation; hardware clears it at end.
// - Start needs key writes 0x55 then 0xAA; otherwise it is rejected.
// - Program and erase are inhibited while write-enable is zero.
// - Improper start sets the sequence error flag; normal completion clears it.
// - Erase codes page and bulk, program codes row and word; others idle.
module psau_top
	import psau_pkg::*;
#(
	parameter int unsigned PADDR_W = 12,
	parameter int unsigned ROW_CLKS = psau_osc_to_clks(ROW_OSC_CYCLES),
	parameter int unsigned PAGE_CLKS = psau_osc_to_clks(PAGE_OSC_CYCLES),
	parameter int unsigned WORD_CLKS = psau_osc_to_clks(WORD_OSC_CYCLES),
	parameter int unsigned BULK_CLKS = psau_osc_to_clks(BULK_OSC_CYCLES)
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire psau_req_s core_req,
	output psau_rsp_s core_rsp,
	output logic core_stall,
	output logic pm_rd,
	output logic [23:0] pm_addr,
	input wire logic [23:0] pm_rdata,
	output psau_nvm_cmd_s nvm_cmd,
	output logic nvm_busy,
	input wire logic [5:0] buf_rd_idx,
	output logic [23:0] buf_rd_data
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH1 = 3'b001,
		ST_FETCH2 = 3'b010,
		ST_TREAD = 3'b011,
		ST_TWRITE = 3'b100
	} psau_state_e;

	if (PADDR_W < 5 || ROW_CLKS < 1 || PAGE_CLKS < 1 || WORD_CLKS < 1 || BULK_CLKS < 1)
	begin : g_bad_param
		$error("address too narrow or operation time below one cycle");
	end

	function automatic logic [15:0] read_format(input psau_op_e op, input logic byte_mode,
		input logic bsel, input logic [23:0] w);
		logic [15:0] r;
		r = 16'h0000;
		if (op == OP_TABLE_READ_LOW)
		begin
			if (!byte_mode)
				r = w[15:0];
			else
				r = {8'h00, bsel ? w[15:8] : w[7:0]};
		end
		else if (!byte_mode || !bsel)
			r = {8'h00, w[23:16]};
		else
			r = 16'h0000;
		return r;
	endfunction

	function automatic logic code_valid(input logic erase, input logic [3:0] opc);
		if (erase)
			return opc == OPC_PAGE_ERASE || opc == OPC_BULK_ERASE;
		else
			return opc == OPC_ROW_PROG || opc == OPC_WORD_PROG;
	endfunction

	psau_state_e state_q;
	psau_req_s req_q;
	logic [7:0] table_page_q;
	logic [7:0] window_page_q;
	logic window_en_q;
	logic wr_q;
	logic write_enable_bit_q;
	logic err_q;
	logic erase_q;
	logic [3:0] opc_q;
	logic [31:0] timer_q;
	logic [23:0] last_waddr_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	psau_rsp_s rsp_q;
	logic pm_rd_q;
	logic [23:0] pm_addr_q;
	psau_nvm_cmd_s nvm_cmd_q;
	logic [23:0] buf_rd_q;

	logic acc_fire;
	logic wr_fire;
	logic addr_ok;
	logic armed;
	logic start_req;
	logic launch;
	logic [23:0] table_addr;
	logic [23:0] window_addr;
	logic window_hit;
	logic buf_wr;
	logic [2:0] buf_lanes;
	logic [23:0] buf_wdata;
	logic [23:0] buf_data;
	logic [1:0] extra;

	assign acc_fire = psel && penable && pready_q;
	assign wr_fire = acc_fire && pwrite;
	assign addr_ok = paddr == PADDR_W'(OFF_TABLE_PAGE) || paddr == PADDR_W'(OFF_WINDOW_PAGE)
		|| paddr == PADDR_W'(OFF_CORE_CTRL) || paddr == PADDR_W'(OFF_FLASH_CTRL)
		|| paddr == PADDR_W'(OFF_UNLOCK_KEY);

	// Table target; bit 23 is the page top bit, so it also selects config space
	assign table_addr = {table_page_q, core_req.effective_address};
	assign window_addr = {1'b0, window_page_q, core_req.effective_address[14:1], 1'b0};
	// Table operations are serialised with window reads in one state machine
	assign window_hit = core_req.op == OP_DATA_READ && core_req.effective_address[15]
		&& window_en_q && state_q == ST_IDLE;

	always_comb
	begin
		if (!core_req.in_repeat)
			extra = core_req.is_move ? 2'd1 : 2'd2;
		else
			extra = core_req.repeat_edge ? 2'd2 : 2'd0;
	end

	// Buffer loading: low half takes bytes 1..0, high half byte 2 unless phantom
	always_comb
	begin
		buf_wr = 1'b0;
		buf_lanes = 3'b000;
		buf_wdata = 24'h00_0000;
		if (state_q == ST_IDLE && core_req.valid && !wr_q)
		begin
			if (core_req.op == OP_TABLE_WRITE_LOW)
			begin
				buf_wr = 1'b1;
				if (!core_req.byte_mode)
				begin
					buf_lanes = 3'b011;
					buf_wdata = {8'h00, core_req.wdata};
				end
				else
				begin
					buf_lanes = core_req.effective_address[0] ? 3'b010 : 3'b001;
					buf_wdata = {8'h00, core_req.wdata[7:0], core_req.wdata[7:0]};
				end
			end
			else if (core_req.op == OP_TABLE_WRITE_HIGH)
			begin
				buf_wr = 1'b1;
				buf_lanes = (core_req.byte_mode && core_req.effective_address[0]) ? 3'b000 : 3'b100;
				buf_wdata = {core_req.wdata[7:0], 16'h0000};
			end
		end
	end

	psau_row_buffer #(
		.WORDS(64),
		.WIDTH(24)
	) u_row_buffer (
		.ref_clk(ref_clk),
		.wr_en(buf_wr),
		.wr_idx(table_addr[6:1]),
		.wr_lanes(buf_lanes),
		.wr_data(buf_wdata),
		.rd_idx(buf_rd_idx),
		.rd_data(buf_data)
	);

	psau_unlock u_unlock (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.bus_wr(wr_fire),
		.key_wr(paddr == PADDR_W'(OFF_UNLOCK_KEY)),
		.key_data(pwdata[7:0]),
		.armed(armed)
	);

	assign start_req = wr_fire && paddr == PADDR_W'(OFF_FLASH_CTRL) && pwdata[WR_BIT] && !wr_q;
	assign launch = start_req && armed && pwdata[WRITE_ENABLE_BIT_BIT]
		&& code_valid(pwdata[ERASE_BIT], pwdata[3:0]);

	// APB slave: answer one cycle into the access phase, act on the pready edge
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !addr_ok;
			if (psel && penable && !pready_q)
			begin
				if (paddr == PADDR_W'(OFF_TABLE_PAGE))
					prdata_q <= {24'h00_0000, table_page_q};
				else if (paddr == PADDR_W'(OFF_WINDOW_PAGE))
					prdata_q <= {24'h00_0000, window_page_q};
				else if (paddr == PADDR_W'(OFF_CORE_CTRL))
					prdata_q <= 32'(window_en_q) << WINDOW_EN_BIT;
				else if (paddr == PADDR_W'(OFF_FLASH_CTRL))
					prdata_q <= {16'h0000, wr_q, write_enable_bit_q, err_q, 6'h00, erase_q, 2'b00, opc_q};
				else
					prdata_q <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			table_page_q <= 8'h00;
			window_page_q <= 8'h00;
			window_en_q <= 1'b0;
		end
		else if (wr_fire)
		begin
			if (paddr == PADDR_W'(OFF_TABLE_PAGE))
				table_page_q <= pwdata[7:0];
			else if (paddr == PADDR_W'(OFF_WINDOW_PAGE))
				window_page_q <= pwdata[7:0];
			else if (paddr == PADDR_W'(OFF_CORE_CTRL))
				window_en_q <= pwdata[WINDOW_EN_BIT];
		end
	end

	// Flash control register; fields stay fixed while an operation runs
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			write_enable_bit_q <= 1'b0;
			erase_q <= 1'b0;
			opc_q <= 4'h0;
		end
		else if (wr_fire && paddr == PADDR_W'(OFF_FLASH_CTRL) && !wr_q)
		begin
			write_enable_bit_q <= pwdata[WRITE_ENABLE_BIT_BIT];
			erase_q <= pwdata[ERASE_BIT];
			opc_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			err_q <= 1'b0;
		else if (start_req && (!armed || !pwdata[WRITE_ENABLE_BIT_BIT]))
			err_q <= 1'b1;
		else if (wr_q && timer_q == 32'd1)
			err_q <= 1'b0;
	end

	// Operation timer: a fixed count derived from the oscillator cycle figure
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			wr_q <= 1'b0;
			timer_q <= 32'd0;
			nvm_cmd_q <= '0;
		end
		else
		begin
			nvm_cmd_q.go <= 1'b0;
			if (launch)
			begin
				wr_q <= 1'b1;
				nvm_cmd_q.go <= 1'b1;
				if (pwdata[ERASE_BIT] && pwdata[3:0] == OPC_PAGE_ERASE)
				begin
					timer_q <= PAGE_CLKS;
					nvm_cmd_q.kind <= NVM_PAGE_ERASE;
					nvm_cmd_q.addr <= last_waddr_q & PAGE_ALIGN_MASK;
				end
				else if (pwdata[ERASE_BIT])
				begin
					timer_q <= BULK_CLKS;
					nvm_cmd_q.kind <= NVM_BULK_ERASE;
					nvm_cmd_q.addr <= 24'h00_0000;
				end
				else if (pwdata[3:0] == OPC_ROW_PROG)
				begin
					timer_q <= ROW_CLKS;
					nvm_cmd_q.kind <= NVM_ROW_PROG;
					nvm_cmd_q.addr <= last_waddr_q & ROW_ALIGN_MASK;
				end
				else
				begin
					timer_q <= WORD_CLKS;
					nvm_cmd_q.kind <= NVM_WORD_PROG;
					nvm_cmd_q.addr <= last_waddr_q & WORD_ALIGN_MASK;
				end
			end
			else if (wr_q)
			begin
				timer_q <= timer_q - 32'd1;
				if (timer_q == 32'd1)
					wr_q <= 1'b0;
			end
		end
	end

	// Core side: table reads, window reads and buffer-loading writes
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			req_q <= '0;
			rsp_q <= '0;
			pm_rd_q <= 1'b0;
			pm_addr_q <= 24'h00_0000;
			last_waddr_q <= 24'h00_0000;
		end
		else
		begin
			rsp_q.done <= 1'b0;
			pm_rd_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					// The core is held off entirely while the flash is busy
					if (core_req.valid && !wr_q)
					begin
						req_q <= core_req;
						if (core_req.op == OP_TABLE_READ_LOW || core_req.op == OP_TABLE_READ_HIGH)
						begin
							pm_rd_q <= 1'b1;
							pm_addr_q <= {table_addr[23:1], 1'b0};
							state_q <= ST_TREAD;
						end
						else if (core_req.op == OP_TABLE_WRITE_LOW || core_req.op == OP_TABLE_WRITE_HIGH)
						begin
							last_waddr_q <= table_addr;
							state_q <= ST_TWRITE;
						end
						else if (window_hit)
						begin
							pm_rd_q <= 1'b1;
							pm_addr_q <= window_addr;
							rsp_q.extra <= extra;
							state_q <= ST_FETCH1;
						end
						else if (core_req.op != OP_NONE)
						begin
							rsp_q.done <= 1'b1;
							rsp_q.hit <= 1'b0;
							rsp_q.rdata <= 16'h0000;
							rsp_q.extra <= 2'd0;
						end
					end
				end
				ST_FETCH1:
				begin
					pm_rd_q <= 1'b1;
					state_q <= ST_FETCH2;
				end
				ST_FETCH2:
				begin
					rsp_q.done <= 1'b1;
					rsp_q.hit <= 1'b1;
					rsp_q.rdata <= pm_rdata[15:0];
					state_q <= ST_IDLE;
				end
				ST_TREAD:
				begin
					rsp_q.done <= 1'b1;
					rsp_q.hit <= 1'b1;
					rsp_q.extra <= 2'd0;
					rsp_q.rdata <= read_format(req_q.op, req_q.byte_mode,
						req_q.effective_address[0], pm_rdata);
					state_q <= ST_IDLE;
				end
				ST_TWRITE:
				begin
					rsp_q.done <= 1'b1;
					rsp_q.hit <= 1'b1;
					rsp_q.rdata <= 16'h0000;
					rsp_q.extra <= 2'd0;
					state_q <= ST_IDLE;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			buf_rd_q <= 24'h00_0000;
		else
			buf_rd_q <= buf_data;
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign core_rsp = rsp_q;
	assign core_stall = wr_q;
	assign pm_rd = pm_rd_q;
	assign pm_addr = pm_addr_q;
	assign nvm_cmd = nvm_cmd_q;
	assign nvm_busy = wr_q;
	assign buf_rd_data = buf_rd_q;
endmodule

/* include/psau_pkg.sv */
// Shared types and constants of the program space access unit.
// Assumes one 100 MHz core clock and a synchronous, active-low reset.
package psau_pkg;
	localparam int unsigned CLK_KHZ = 100000;
	localparam int unsigned FRC_KHZ = 7370;
	localparam int unsigned ROW_OSC_CYCLES = 11064;
	localparam int unsigned PAGE_OSC_CYCLES = 11064;
	localparam int unsigned WORD_OSC_CYCLES = 11064;
	localparam int unsigned BULK_OSC_CYCLES = 11064;
	localparam logic [11:0] OFF_TABLE_PAGE = 12'h000;
	localparam logic [11:0] OFF_WINDOW_PAGE = 12'h004;
	localparam logic [11:0] OFF_CORE_CTRL = 12'h008;
	localparam logic [11:0] OFF_FLASH_CTRL = 12'h00c;
	localparam logic [11:0] OFF_UNLOCK_KEY = 12'h010;
	localparam int unsigned WINDOW_EN_BIT = 2;
	localparam int unsigned WR_BIT = 15;
	localparam int unsigned WRITE_ENABLE_BIT_BIT = 14;
	localparam int unsigned ERR_BIT = 13;
	localparam int unsigned ERASE_BIT = 6;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [3:0] OPC_PAGE_ERASE = 4'h2;
	localparam logic [3:0] OPC_BULK_ERASE = 4'hf;
	localparam logic [3:0] OPC_ROW_PROG = 4'h1;
	localparam logic [3:0] OPC_WORD_PROG = 4'h3;
	localparam logic [23:0] PAGE_ALIGN_MASK = 24'hff_fc00;
	localparam logic [23:0] ROW_ALIGN_MASK = 24'hff_ff80;
	localparam logic [23:0] WORD_ALIGN_MASK = 24'hff_fffe;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_TABLE_READ_LOW = 3'b001,
		OP_TABLE_READ_HIGH = 3'b010,
		OP_TABLE_WRITE_LOW = 3'b011,
		OP_TABLE_WRITE_HIGH = 3'b100,
		OP_DATA_READ = 3'b101
	} psau_op_e;
	typedef enum logic [1:0] {
		NVM_PAGE_ERASE = 2'b00,
		NVM_BULK_ERASE = 2'b01,
		NVM_ROW_PROG = 2'b10,
		NVM_WORD_PROG = 2'b11
	} psau_nvm_e;
	typedef struct packed {
		logic valid;
		psau_op_e op;
		logic byte_mode;
		logic [15:0] effective_address;
		logic [15:0] wdata;
		logic is_move;
		logic in_repeat;
		logic repeat_edge;
	} psau_req_s;
	typedef struct packed {
		logic done;
		logic hit;
		logic [15:0] rdata;
		logic [1:0] extra;
	} psau_rsp_s;
	typedef struct packed {
		logic go;
		psau_nvm_e kind;
		logic [23:0] addr;
	} psau_nvm_cmd_s;
	function automatic int unsigned psau_osc_to_clks(input int unsigned osc);
		longint unsigned t;
		t = (longint'(osc) * CLK_KHZ + FRC_KHZ - 1) / FRC_KHZ;
		return int'(t);
	endfunction
endpackage

/* rtl/psau_unlock.sv */
// Two-write unlock key sequencer for flash program and erase starts.
// Assumes every register write is reported on bus_wr for exactly one cycle.
module psau_unlock
	import psau_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic bus_wr,
	input wire logic key_wr,
	input wire logic [7:0] key_data,
	output logic armed
);
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_HALF = 2'b01,
		KEY_ARMED = 2'b10
	} psau_key_e;
	psau_key_e key_q;
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			key_q <= KEY_IDLE;
		else if (bus_wr)
		begin
			// Any write not continuing the sequence drops it
			if (key_wr && key_data == KEY_FIRST)
				key_q <= KEY_HALF;
			else if (key_wr && key_data == KEY_SECOND && key_q == KEY_HALF)
				key_q <= KEY_ARMED;
			else
				key_q <= KEY_IDLE;
		end
	end
	assign armed = (key_q == KEY_ARMED);
endmodule

/* rtl/psau_row_buffer.sv */
// Holding buffers for one program row, written by byte lanes.
// Assumes the reader tolerates one cycle of read latency.
module psau_row_buffer #(
	parameter int unsigned WORDS = 64,
	parameter int unsigned WIDTH = 24
) (
	input wire logic ref_clk,
	input wire logic wr_en,
	input wire logic [$clog2(WORDS)-1:0] wr_idx,
	input wire logic [WIDTH/8-1:0] wr_lanes,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(WORDS)-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [WORDS];
	if (WIDTH % 8 != 0 || (WORDS & (WORDS - 1)) != 0)
	begin : g_bad_size
		$error("row buffer needs whole bytes and a power-of-two depth");
	end
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < WIDTH / 8; i++)
		begin
			if (wr_en && wr_lanes[i])
				mem[wr_idx][i*8 +: 8] <= wr_data[i*8 +: 8];
		end
	end
	always_ff @(posedge ref_clk)
	begin
		rd_data <= mem[rd_idx];
	end
endmodule

/* verification/psau_pm_model.sv */
// Program memory model answering the unit's read strobe.
// Assumes pm_rdata is sampled at the edge that closes the pm_rd cycle.
module psau_pm_model (
	input wire logic ref_clk,
	input wire logic pm_rd,
	input wire logic [23:0] pm_addr,
	output logic [23:0] pm_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] pat;
	// Word pattern follows the address; lines show the inverse when no read stands
	assign pat = {pm_addr[7:0] ^ 8'h5a, pm_addr[15:0] ^ 16'ha5c3};
	assign pm_rdata = pm_rd ? pat : ~pat;
endmodule

/* verification/psau_checker.sv */
// Concurrent checks on the ports of the program space access unit.
// Assumes OP_CLKS equals every operation length set on the unit.
module psau_checker
	import psau_pkg::*;
#(
	parameter int unsigned OP_CLKS = 20
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire psau_req_s core_req,
	input wire psau_rsp_s core_rsp,
	input wire logic core_stall,
	input wire logic pm_rd,
	input wire logic [23:0] pm_addr,
	input wire psau_nvm_cmd_s nvm_cmd,
	input wire logic nvm_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] busy_cnt_q;
	logic [1:0] exp_extra;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	assign exp_extra = core_req.in_repeat ? (core_req.repeat_edge ? 2'h2 : 2'h0) : (core_req.is_move ? 2'h1 : 2'h2);
	// Length of the current busy stretch
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			busy_cnt_q <= 32'h0000_0000;
		else if (nvm_busy)
			busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
		else
			busy_cnt_q <= 32'h0000_0000;
	end
	sequence s_access_wait;
		psel && penable && !pready;
	endsequence
	sequence s_two_fetch;
		pm_rd ##1 pm_rd;
	endsequence
	property p_ready_late;
		s_access_wait |=> pready ##1 !pready;
	endproperty
	property p_err_with_ready;
		pslverr |-> pready && psel && penable;
	endproperty
	property p_fetch_done;
		pm_rd |-> ##[1:2] core_rsp.done;
	endproperty
	property p_win_addr;
		s_two_fetch |-> (!pm_addr[0] && !pm_addr[23]) ##1 core_rsp.done;
	endproperty
	property p_extra;
		s_two_fetch |=> core_rsp.done && core_rsp.extra == $past(exp_extra, 3);
	endproperty
	property p_stall;
		nvm_busy |-> core_stall;
	endproperty
	property p_go;
		nvm_cmd.go |-> nvm_busy ##1 !nvm_cmd.go;
	endproperty
	property p_length;
		$fell(nvm_busy) |-> busy_cnt_q == OP_CLKS;
	endproperty
	property p_row_align;
		nvm_cmd.go && nvm_cmd.kind == NVM_ROW_PROG |-> (nvm_cmd.addr & ~ROW_ALIGN_MASK) == 24'h00_0000;
	endproperty
	a_ready_late: assert property (p_ready_late) else $error("pready not one cycle after access wait");
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr outside pready");
	a_fetch_done: assert property (p_fetch_done) else $error("read not answered in time");
	a_win_addr: assert property (p_win_addr) else $error("window fetch address wrong");
	a_extra: assert property (p_extra) else $error("window penalty wrong");
	a_stall: assert property (p_stall) else $error("core not stalled while busy");
	a_go: assert property (p_go) else $error("launch pulse wrong");
	a_length: assert property (p_length) else $error("operation length wrong");
	a_row_align: assert property (p_row_align) else $error("row address not aligned");
endmodule

bind psau_top psau_checker #(
	.OP_CLKS(ROW_CLKS)
) i_psau_checker (
	.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .core_req(core_req), .core_rsp(core_rsp), .core_stall(core_stall),
	.pm_rd(pm_rd), .pm_addr(pm_addr), .nvm_cmd(nvm_cmd), .nvm_busy(nvm_busy)
);

/* verification/psau_top_tb.sv */
// Self-checking bench for the program space access unit.
// Assumes the program memory model and the bound checker beside the unit.
module psau_top_tb
	import psau_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned N_CLKS = 20;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	psau_req_s req = '0;
	psau_rsp_s rsp;
	logic core_stall;
	logic pm_rd;
	logic [23:0] pm_addr;
	logic [23:0] pm_rdata;
	psau_nvm_cmd_s nvm_cmd;
	logic nvm_busy;
	logic [5:0] buf_rd_idx = 6'h00;
	logic [23:0] buf_rd_data;
	logic [23:0] last_pa;
	logic apb_err;
	int n_errors = 0;
	int num_checks = 0;
	int n_go = 0;
	psau_nvm_e go_kind;
	logic [23:0] go_addr;
	logic [2:0] fls [5] = '{3'h4, 3'h0, 3'h2, 3'h3, 3'h7};
	logic [31:0] ctl [5] = '{32'h0000_4042, 32'h0000_404f, 32'h0000_4001, 32'h0000_4003, 32'h0000_4002};
	psau_nvm_e knd [4] = '{NVM_PAGE_ERASE, NVM_BULK_ERASE, NVM_ROW_PROG, NVM_WORD_PROG};
	logic [23:0] adr [4] = '{24'h00_08c6 & PAGE_ALIGN_MASK, 24'h00_0000, 24'h00_08c6 & ROW_ALIGN_MASK,
		24'h00_08c6 & WORD_ALIGN_MASK};

	initial forever #5 ref_clk = ~ref_clk;

	psau_top #(.ROW_CLKS(N_CLKS), .PAGE_CLKS(N_CLKS), .WORD_CLKS(N_CLKS), .BULK_CLKS(N_CLKS)) i_psau_top (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_req(req),
		.core_rsp(rsp), .core_stall(core_stall), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
		.nvm_cmd(nvm_cmd), .nvm_busy(nvm_busy), .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data)
	);
	psau_pm_model i_psau_pm_model (.ref_clk(ref_clk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata));

	always @(posedge ref_clk)
	begin
		if (pm_rd === 1'b1)
			last_pa <= pm_addr;
		if (nvm_cmd.go === 1'b1)
		begin
			n_go <= n_go + 1;
			go_kind <= nvm_cmd.kind;
			go_addr <= nvm_cmd.addr;
		end
	end

	function automatic logic [23:0] pw(input logic [23:0] a);
		return {a[7:0] ^ 8'h5a, a[15:0] ^ 16'ha5c3};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude();
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		r = prdata;
		apb_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		chk(nm, r, e);
	endtask

	// The idle unit takes valid at the next edge and again once idle, so valid stands
	// for the take edge only; lat counts edges from take to done
	task automatic core_do(input psau_op_e op, input logic bm, input logic [15:0] ea, input logic [15:0] wd,
		input logic [2:0] fl, output int lat);
		int n;
		@(posedge ref_clk);
		req <= '{1'b1, op, bm, ea, wd, fl[2], fl[1], fl[0]};
		@(posedge ref_clk);
		req.valid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (rsp.done !== 1'b1);
		lat = n;
	endtask

	task automatic start(input logic [31:0] d, input logic unl, output logic st);
		int n;
		if (unl)
		begin
			wr(OFF_UNLOCK_KEY, {24'h00_0000, KEY_FIRST});
			wr(OFF_UNLOCK_KEY, {24'h00_0000, KEY_SECOND});
		end
		wr(OFF_FLASH_CTRL, d);
		repeat (2) @(posedge ref_clk);
		st = core_stall;
		n = 0;
		while (nvm_busy !== 1'b0 && n < 200)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk("busy end", nvm_busy, 0);
	endtask

	initial
	begin
		logic [31:0] r;
		logic [23:0] p;
		logic [15:0] e;
		logic [7:0] pg;
		logic st;
		int lat;
		int g;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		wr(OFF_WINDOW_PAGE, 32'h0000_0012);
		wr(OFF_CORE_CTRL, 32'h0000_0004);
		rdc("window page", OFF_WINDOW_PAGE, 32'h0000_0012);
		rdc("core control", OFF_CORE_CTRL, 32'h0000_0004);
		rdc("unlock key", OFF_UNLOCK_KEY, 32'h0000_0000);
		apb(1'b0, 12'h020, 32'h0000_0000, r);
		chk("unmapped error", apb_err, 1);
		chk("unmapped data", r, 0);
		// Table reads run with the window enabled, so the window must stand aside
		for (int j = 0; j < 2; j++)
		begin
			pg = j ? 8'h85 : 8'h05;
			wr(OFF_TABLE_PAGE, {24'h00_0000, pg});
			p = pw({pg, 16'h8abc});
			for (int k = 0; k < 6; k++)
			begin
				core_do(k < 3 ? OP_TABLE_READ_LOW : OP_TABLE_READ_HIGH, k % 3 != 0, 16'h8abc | 16'(k % 3 == 2),
					16'h0000, 3'h0, lat);
				case (k)
					0: e = p[15:0];
					1: e = {8'h00, p[7:0]};
					2: e = {8'h00, p[15:8]};
					3, 4: e = {8'h00, p[23:16]};
					default: e = 16'h0000;
				endcase
				chk("table data", rsp.rdata, e);
				chk("table address", last_pa, {pg, 16'h8abc});
				chk("table latency", lat, 2);
			end
		end
		rdc("table page", OFF_TABLE_PAGE, 32'h0000_0085);
		p = pw(24'h09_0abc);
		for (int k = 0; k < 5; k++)
		begin
			core_do(OP_DATA_READ, 1'b0, 16'h8abd, 16'h0000, fls[k], lat);
			chk("window hit", rsp.hit, 1);
			chk("window data", rsp.rdata, p[15:0]);
			chk("window address", last_pa, 24'h09_0abc);
			chk("window latency", lat, 3);
			chk("window extra", rsp.extra, fls[k][1] ? (fls[k][0] ? 2 : 0) : (fls[k][2] ? 1 : 2));
		end
		core_do(OP_DATA_READ, 1'b0, 16'h0abd, 16'h0000, 3'h0, lat);
		chk("low data hit", rsp.hit, 0);
		wr(OFF_CORE_CTRL, 32'h0000_0000);
		core_do(OP_DATA_READ, 1'b0, 16'h8abd, 16'h0000, 3'h0, lat);
		chk("disabled hit", rsp.hit, 0);
		chk("plain latency", lat, 1);
		wr(OFF_TABLE_PAGE, 32'h0000_0000);
		// Byte-mode loads; the last one aims at the phantom byte and must be dropped
		for (int k = 0; k < 4; k++)
			core_do(k < 2 ? OP_TABLE_WRITE_LOW : OP_TABLE_WRITE_HIGH, 1'b1, 16'h08c8 | 16'(k % 2),
				{8'h00, 8'(32'hee69_a73c >> (8 * k))}, 3'h0, lat);
		core_do(OP_TABLE_WRITE_LOW, 1'b0, 16'h08c6, 16'h1357, 3'h0, lat);
		chk("write latency", lat, 2);
		core_do(OP_TABLE_WRITE_HIGH, 1'b0, 16'h08c6, 16'h0024, 3'h0, lat);
		chk("write latency", lat, 2);
		buf_rd_idx <= 6'h23;
		repeat (3) @(posedge ref_clk);
		chk("holding buffer", buf_rd_data, 24'h24_1357);
		buf_rd_idx <= 6'h24;
		repeat (3) @(posedge ref_clk);
		chk("holding buffer bytes", buf_rd_data, 24'h69_a73c);
		start(32'h0000_c001, 1'b0, st);
		rdc("start without key", OFF_FLASH_CTRL, 32'h0000_6001);
		wr(OFF_UNLOCK_KEY, {24'h00_0000, KEY_FIRST});
		wr(OFF_TABLE_PAGE, 32'h0000_0000);
		wr(OFF_UNLOCK_KEY, {24'h00_0000, KEY_SECOND});
		wr(OFF_FLASH_CTRL, 32'h0000_c001);
		rdc("broken key", OFF_FLASH_CTRL, 32'h0000_6001);
		start(32'h0000_8001, 1'b1, st);
		rdc("write disabled", OFF_FLASH_CTRL, 32'h0000_2001);
		chk("no launch", n_go, 0);
		for (int i = 0; i < 5; i++)
		begin
			g = n_go;
			start(ctl[i] | 32'h0000_8000, 1'b1, st);
			chk("launch count", n_go, g + (i < 4));
			chk("core stall", st, i < 4);
			if (i < 4)
			begin
				chk("launch kind", go_kind, knd[i]);
				chk("launch address", go_addr, adr[i]);
			end
			rdc("flash control", OFF_FLASH_CTRL, ctl[i]);
		end
		conclude();
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		conclude();
	end
endmodule
